// File: common/sers_pkg.sv
// shared constants and types for the eeprom read sequencer pair
package sers_pkg;

  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 8;
  localparam int         MEM_DEPTH     = 256;
  // upper nibble every device address byte must carry
  localparam logic [3:0] DEV_ID        = 4'ha;
  // don't-care middle bits of the device address, host sends zero
  localparam logic [2:0] SUB_ADDR      = 3'h0;
  // bit counter values: ninth clock is the acknowledge slot
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [3:0] BIT_END       = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  // host serial clock timing
  localparam int         CLK_PERIOD_PS = 4000;
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         QTR_CYC       = (SCL_PERIOD_NS * 1000) / (4 * CLK_PERIOD_PS);
  localparam logic [7:0] QTR_LAST      = 8'(QTR_CYC - 1);

  typedef enum logic [2:0] {D_IDLE, D_DEV, D_WADR, D_WIGN, D_READ} sers_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_SEND, H_RECV, H_STOP} sers_host_st_t;
  typedef enum logic [1:0] {SEG_DEVW, SEG_WADR, SEG_DEVR} sers_seg_t;

endpackage : sers_pkg

// File: common/sers_if.sv
// two-wire link between host and memory, open-drain data resolved here
`timescale 1ns/10ps
`default_nettype none
interface sers_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;

  // pulled-up wire: low whenever either party drives
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport host (output scl, output sda_host_oe, input sda);
  modport mem  (input scl, input sda, output sda_dev_oe);
endinterface : sers_if
`default_nettype wire

// File: rtl/sers_mem.sv
// memory end: link-clocked read sequencer with a preload port on clk
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - read address byte acknowledged on ninth clock
// - send byte at counter, then counter plus one
// - host ack on 18th clock gets next byte
// - bytes keep coming while each is acknowledged
// - counter wraps from top to address zero
// - host ends read with no-ack then stop
// - write address byte acked, word address follows
// - word address acked and loaded, nothing programmed
// - new start abandons write, read follows
// - accept only id 1010, low bit is direction
// - counter keeps last address plus one
// - ack device and word address bytes by pulling data low
// - stop returns engine to idle standby
module sers_mem
(
  sers_if.mem                             link,
  input  wire logic                       link_clk,
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       ld_valid,
  output logic                            ld_ready,
  input  wire logic [sers_pkg::ADDR_W-1:0] ld_addr,
  input  wire logic [sers_pkg::DATA_W-1:0] ld_data
);
  import sers_pkg::*;

  // counter step; 8-bit overflow gives the wrap to the array start
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
    next_addr = a + 8'h01;
  endfunction : next_addr

  ////////////////////////////////////////////////////////////////////////////
  // preload port, clk side: toggle request, data held until the echo returns

  logic              req_q;
  logic              req_d;
  logic [ADDR_W-1:0] la_q;
  logic [ADDR_W-1:0] la_d;
  logic [DATA_W-1:0] ld_q;
  logic [DATA_W-1:0] ld_d;
  logic              ack_m_q;
  logic              ack_s_q;
  logic              wack_q;

  // ready only once the link side has echoed the last toggle
  assign ld_ready = (req_q == ack_s_q);

  // capture a preload word; held stable so the link side reads it safely
  always_comb
  begin
    req_d = req_q;
    la_d  = la_q;
    ld_d  = ld_q;
    if (ld_valid && ld_ready)
    begin
      req_d = ~req_q;
      la_d  = ld_addr;
      ld_d  = ld_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_q   <= 1'b0;
      la_q    <= '0;
      ld_q    <= '0;
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end
    else
    begin
      req_q   <= req_d;
      la_q    <= la_d;
      ld_q    <= ld_d;
      ack_m_q <= wack_q;  // first stage, read only by the second
      ack_s_q <= ack_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side synchronisers for the pins and the preload toggle

  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;
  logic req_m_q;
  logic req_s_q;

  // third stage gives the previous synchronised level for edge checks
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
    end
    else
    begin
      scl_m_q <= link.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      req_m_q <= req_q;
      req_s_q <= req_m_q;
    end
  end

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // start and stop are data edges while the clock stays high
  assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign rise_c  = scl_s_q & ~scl_p_q;
  assign fall_c  = ~scl_s_q & scl_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // array storage; only the preload port writes it, the link never does

  logic [DATA_W-1:0] mem_q [MEM_DEPTH];
  logic              we_c;

  assign we_c = (req_s_q != wack_q);

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wack_q <= 1'b0;
    end
    else
    begin
      wack_q <= req_s_q;
    end
  end

  // no reset on the array: contents are data, not control
  always_ff @(posedge link_clk)
  begin
    if (we_c)
    begin
      mem_q[la_q] <= ld_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  sers_dev_st_t      st_q;
  sers_dev_st_t      st_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  logic [DATA_W-1:0] sh_q;
  logic [DATA_W-1:0] sh_d;
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] ptr_d;
  logic              oe_q;
  logic              oe_d;
  logic              hack_q;
  logic              hack_d;

  // open-drain: only ever pulls low
  assign link.sda_dev_oe = oe_q;

  // bit counter counts rising clocks; falls move the data line
  always_comb
  begin
    st_d   = st_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    oe_d   = oe_q;
    hack_d = hack_q;
    if (start_c)
    begin
      st_d  = D_DEV;
      bit_d = '0;
      oe_d  = 1'b0;
    end
    else if (stop_c)
    begin
      st_d = D_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        D_IDLE, D_WIGN:
        begin
          // wait for a start; write data after a dummy write is not taken
        end
        D_DEV, D_WADR:
        begin
          if (rise_c && bit_q != BIT_END)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q < BIT_ACK)
            begin
              sh_d = {sh_q[DATA_W-2:0], sda_s_q};
            end
          end
          if (fall_c && bit_q == BIT_ACK)
          begin
            if (st_q == D_WADR)
            begin
              oe_d  = 1'b1;
              ptr_d = sh_q;
            end
            else if (sh_q[7:4] == DEV_ID)
            begin
              oe_d = 1'b1;
            end
            else
            begin
              st_d = D_IDLE;
            end
          end
          if (fall_c && bit_q == BIT_END)
          begin
            oe_d  = 1'b0;
            bit_d = '0;
            if (st_q == D_WADR)
            begin
              st_d = D_WIGN;
            end
            else if (sh_q[0])
            begin
              st_d  = D_READ;
              sh_d  = mem_q[ptr_q];
              ptr_d = next_addr(ptr_q);
              oe_d  = ~mem_q[ptr_q][7];
            end
            else
            begin
              st_d = D_WADR;
            end
          end
        end
        D_READ:
        begin
          if (rise_c && bit_q != BIT_END)
          begin
            bit_d = bit_q + 4'h1;
            if (bit_q == BIT_ACK)
            begin
              hack_d = ~sda_s_q;
            end
          end
          if (fall_c)
          begin
            if (bit_q == BIT_ACK)
            begin
              oe_d = 1'b0;
            end
            else if (bit_q == BIT_END)
            begin
              bit_d = '0;
              if (hack_q)
              begin
                sh_d  = mem_q[ptr_q];
                ptr_d = next_addr(ptr_q);
                oe_d  = ~mem_q[ptr_q][7];
              end
              else
              begin
                st_d = D_IDLE;
                oe_d = 1'b0;
              end
            end
            else if (bit_q != 4'h0)
            begin
              sh_d = {sh_q[DATA_W-2:0], 1'b0};
              oe_d = ~sh_q[DATA_W-2];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= D_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      ptr_q  <= ADDR_RST;
      oe_q   <= 1'b0;
      hack_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      oe_q   <= oe_d;
      hack_q <= hack_d;
    end
  end

endmodule : sers_mem
`default_nettype wire

// File: rtl/sers_host.sv
// host end: serial clock from a divider, random or current-address reads
`timescale 1ns/10ps
`default_nettype none
module sers_host
(
  sers_if.host                             link,
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire logic                        cmd_random,
  input  wire logic [sers_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]                  cmd_len,
  output logic                             rd_valid,
  output logic [sers_pkg::DATA_W-1:0]      rd_data,
  output logic                             done,
  output logic                             nack
);
  import sers_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // data line comes back through two flops on the host's own clk

  logic sda_m_q;
  logic sda_s_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end
    else
    begin
      sda_m_q <= link.sda;
      sda_s_q <= sda_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit engine: four quarter phases per bit, each QTR_CYC clocks long

  sers_host_st_t     st_q;
  sers_host_st_t     st_d;
  sers_seg_t         seg_q;
  sers_seg_t         seg_d;
  logic [1:0]        ph_q;
  logic [1:0]        ph_d;
  logic [7:0]        div_q;
  logic [7:0]        div_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  logic [DATA_W-1:0] sh_q;
  logic [DATA_W-1:0] sh_d;
  logic [ADDR_W-1:0] adr_q;
  logic [ADDR_W-1:0] adr_d;
  logic [7:0]        left_q;
  logic [7:0]        left_d;
  logic              scl_q;
  logic              scl_d;
  logic              oe_q;
  logic              oe_d;
  logic              ack_q;
  logic              ack_d;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] rdat_d;
  logic              rv_q;
  logic              rv_d;
  logic              done_q;
  logic              done_d;
  logic              nack_q;
  logic              nack_d;
  logic              tick;

  assign tick             = (div_q == QTR_LAST);
  assign cmd_ready        = (st_q == H_IDLE);
  assign link.scl         = scl_q;
  assign link.sda_host_oe = oe_q;
  assign rd_valid         = rv_q;
  assign rd_data          = rdat_q;
  assign done             = done_q;
  assign nack             = nack_q;

  // clock edges fall on quarter ends; data moves only while the clock is low, except for start and stop
  always_comb
  begin
    st_d   = st_q;
    seg_d  = seg_q;
    ph_d   = ph_q;
    div_d  = tick ? 8'h00 : div_q + 8'h01;
    bit_d  = bit_q;
    sh_d   = sh_q;
    adr_d  = adr_q;
    left_d = left_q;
    scl_d  = scl_q;
    oe_d   = oe_q;
    ack_d  = ack_q;
    rdat_d = rdat_q;
    rv_d   = 1'b0;
    done_d = 1'b0;
    nack_d = nack_q;
    if (st_q == H_IDLE)
    begin
      div_d = 8'h00;
      if (cmd_valid)
      begin
        st_d   = H_START;
        ph_d   = 2'h0;
        adr_d  = cmd_addr;
        left_d = cmd_len;
        nack_d = 1'b0;
        seg_d  = cmd_random ? SEG_DEVW : SEG_DEVR;
        sh_d   = {DEV_ID, SUB_ADDR, ~cmd_random};
      end
    end
    else if (tick)
    begin
      ph_d = ph_q + 2'h1;
      unique case (ph_q)
        2'h0: scl_d = 1'b1;
        2'h1:
        begin
          if (st_q == H_START)
          begin
            oe_d = 1'b1;  // data falls with clock high: start
          end
          else if (st_q == H_STOP)
          begin
            oe_d = 1'b0;
          end
          else if (st_q == H_SEND && bit_q == BIT_ACK)
          begin
            ack_d = ~sda_s_q;
          end
          else if (st_q == H_RECV && bit_q != BIT_ACK)
          begin
            sh_d = {sh_q[DATA_W-2:0], sda_s_q};
            if (bit_q == BIT_LAST_DATA)
            begin
              rdat_d = {sh_q[DATA_W-2:0], sda_s_q};
              rv_d   = 1'b1;
            end
          end
        end
        2'h2: scl_d = (st_q == H_STOP);
        2'h3:
        begin
          unique case (st_q)
            H_START:
            begin
              st_d  = H_SEND;
              bit_d = 4'h0;
              oe_d  = ~sh_q[DATA_W-1];
            end
            H_SEND:
            begin
              if (bit_q != BIT_ACK)
              begin
                bit_d = bit_q + 4'h1;
                sh_d  = {sh_q[DATA_W-2:0], 1'b0};
                oe_d  = (bit_q == BIT_LAST_DATA) ? 1'b0 : ~sh_q[DATA_W-2];
              end
              else if (!ack_q)
              begin
                st_d   = H_STOP;
                oe_d   = 1'b1;
                nack_d = 1'b1;
              end
              else
              begin
                bit_d = 4'h0;
                unique case (seg_q)
                  SEG_DEVW:
                  begin
                    seg_d = SEG_WADR;
                    sh_d  = adr_q;
                    oe_d  = ~adr_q[ADDR_W-1];
                  end
                  SEG_WADR:
                  begin
                    seg_d = SEG_DEVR;
                    st_d  = H_START;
                    sh_d  = {DEV_ID, SUB_ADDR, 1'b1};
                    oe_d  = 1'b0;
                  end
                  SEG_DEVR:
                  begin
                    st_d = H_RECV;
                    oe_d = 1'b0;
                  end
                endcase
              end
            end
            H_RECV:
            begin
              if (bit_q != BIT_ACK)
              begin
                bit_d = bit_q + 4'h1;
                if (bit_q == BIT_LAST_DATA)
                begin
                  oe_d = (left_q != 8'h00);
                end
              end
              else if (left_q != 8'h00)
              begin
                left_d = left_q - 8'h01;
                bit_d  = 4'h0;
                oe_d   = 1'b0;
              end
              else
              begin
                st_d = H_STOP;
                oe_d = 1'b1;
              end
            end
            H_STOP:
            begin
              st_d   = H_IDLE;
              done_d = 1'b1;
            end
            H_IDLE:
            begin
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q   <= H_IDLE;
      seg_q  <= SEG_DEVR;
      ph_q   <= 2'h0;
      div_q  <= 8'h00;
      bit_q  <= 4'h0;
      sh_q   <= '0;
      adr_q  <= '0;
      left_q <= 8'h00;
      scl_q  <= 1'b1;
      oe_q   <= 1'b0;
      ack_q  <= 1'b0;
      rdat_q <= '0;
      rv_q   <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      seg_q  <= seg_d;
      ph_q   <= ph_d;
      div_q  <= div_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      adr_q  <= adr_d;
      left_q <= left_d;
      scl_q  <= scl_d;
      oe_q   <= oe_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      rv_q   <= rv_d;
      done_q <= done_d;
      nack_q <= nack_d;
    end
  end

endmodule : sers_host
`default_nettype wire

// File: tb/sers_link_props.sv
// wire-level checker for the host to memory two-wire link
`timescale 1ns/10ps
`default_nettype none
module sers_link_props
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic       scl_p_q;
  logic       sda_p_q;
  logic       nk_q;
  logic       dir_q;
  logic [3:0] cnt_q;
  logic [1:0] idx_q;
  logic [7:0] sh_q;
  logic       rise;
  logic       start_ev;
  logic       stop_ev;
  logic       ninth;

  //////////////////////////////////////////////////////////////////////////////
  // framing seen on the resolved wire, sampled on clk as a fast observer
  assign rise     = scl & ~scl_p_q;
  assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_ev  = scl & scl_p_q & ~sda_p_q & sda;
  assign ninth    = rise & (cnt_q == 4'h8);

  // bit count within a byte, byte index since start (saturates at 3), last ack level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
      cnt_q   <= 4'h0;
      idx_q   <= 2'h0;
      sh_q    <= 8'h00;
      nk_q    <= 1'h1;
      dir_q   <= 1'h0;
    end
    else
    begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      if (start_ev)
      begin
        cnt_q <= 4'h0;
        idx_q <= 2'h0;
      end
      else if (rise)
      begin
        sh_q  <= ninth ? sh_q : {sh_q[6:0], sda};
        cnt_q <= ninth ? 4'h0 : cnt_q + 4'h1;
        idx_q <= (ninth && idx_q != 2'h3) ? idx_q + 2'h1 : idx_q;
        nk_q  <= (ninth && idx_q != 2'h0) ? sda : nk_q;
        dir_q <= (ninth && idx_q == 2'h0) ? sh_q[0] : dir_q;  // read when set
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory only moves its data line while the clock is low
  dev_stable_high_a: assert property (scl && scl_p_q |-> $stable(sda_dev_oe))
    else $error("memory moved data while clock high");
  write_addr_ack_a: assert property (ninth && idx_q == 2'h0 && sh_q == 8'ha0 |-> sda_dev_oe)
    else $error("write address byte not acknowledged");
  read_addr_ack_a: assert property (ninth && idx_q == 2'h0 && sh_q == 8'ha1 |-> sda_dev_oe)
    else $error("read address byte not acknowledged");
  // direction of the transfer is the low bit of its first byte, held in dir_q
  word_addr_ack_a: assert property (ninth && idx_q == 2'h1 && !dir_q |-> sda_dev_oe)
    else $error("word address byte not acknowledged");
  data_release_a: assert property (ninth && idx_q != 2'h0 && dir_q |-> !sda_dev_oe)
    else $error("memory held data line in read acknowledge slot");
  host_quiet_data_a: assert property (rise && cnt_q < 4'h8 && idx_q != 2'h0 && sda_dev_oe
    |-> !sda_host_oe)
    else $error("host drove data line during read data bits");
  stop_nack_a: assert property (stop_ev && idx_q > 2'h1 |-> nk_q)
    else $error("read ended without a final no-ack");
  idle_after_stop_a: assert property (stop_ev |=> !sda_dev_oe [*8])
    else $error("memory drove data line after stop");
endmodule : sers_link_props
`default_nettype wire

// File: tb/serial_eeprom_read_sequencer_tb.sv
// self-checking bench: host and memory joined, plus a bit-banged second memory
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_read_sequencer_tb;
  import sers_pkg::*;
  logic              clk;
  logic              link_clk;
  logic              arst_n;
  logic              ld_valid;
  logic              ld_ready;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              cmd_random;
  logic [ADDR_W-1:0] ld_addr;
  logic [ADDR_W-1:0] cmd_addr;
  logic [ADDR_W-1:0] ctr_m;
  logic [ADDR_W-1:0] ra;
  logic [DATA_W-1:0] ld_data;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] mem_m [MEM_DEPTH];
  logic [7:0]        cmd_len;
  logic              rd_valid;
  logic              done;
  logic              nack;
  logic              bb_ack;
  logic [31:0]       seed;
  int                num_errors;
  int                n_checks;

  sers_if lk ();
  sers_if bb ();

  //////////////////////////////////////////////////////////////////////////////
  sers_mem sers_mem_i
  (
    .link     (lk),
    .link_clk (link_clk),
    .clk      (clk),
    .arst_n   (arst_n),
    .ld_valid (ld_valid),
    .ld_ready (ld_ready),
    .ld_addr  (ld_addr),
    .ld_data  (ld_data)
  );
  // second memory faces the bench's own bit-banged driver, never preloaded
  sers_mem sers_mem_bb_i
  (
    .link     (bb),
    .link_clk (link_clk),
    .clk      (clk),
    .arst_n   (arst_n),
    .ld_valid (1'h0),
    .ld_ready (),
    .ld_addr  (8'h00),
    .ld_data  (8'h00)
  );
  sers_host sers_host_i
  (
    .link       (lk),
    .clk        (clk),
    .arst_n     (arst_n),
    .cmd_valid  (cmd_valid),
    .cmd_ready  (cmd_ready),
    .cmd_random (cmd_random),
    .cmd_addr   (cmd_addr),
    .cmd_len    (cmd_len),
    .rd_valid   (rd_valid),
    .rd_data    (rd_data),
    .done       (done),
    .nack       (nack)
  );
  sers_link_props sers_link_props_i
  (
    .clk         (clk),
    .arst_n      (arst_n),
    .scl         (lk.scl),
    .sda         (lk.sda),
    .sda_host_oe (lk.sda_host_oe),
    .sda_dev_oe  (lk.sda_dev_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // user clock and an unrelated link clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'h0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  // expected byte: counter walks up and wraps at the top of the array
  function automatic logic [DATA_W-1:0] exp_byte(input logic [7:0] base, input logic [7:0] i);
    logic [ADDR_W-1:0] a;
    a = base + i;
    return mem_m[a];
  endfunction : exp_byte

  task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
    n_checks++;
    if (seen !== expd)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, expd);
    end
  endtask : chk

  task automatic conclude;
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic give_up;
    num_errors++;
    conclude();
  endtask : give_up

  // one preload over the toggle handshake; refusals are avoided by waiting for ready
  task automatic preload(input logic [7:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 100 && ld_ready !== 1'h1; k++)
      @(negedge clk);
    if (k == 100)
      give_up();
    ld_valid = 1'h1;
    ld_addr  = a;
    ld_data  = d;
    @(negedge clk);
    ld_valid = 1'h0;
    chk(ld_ready, 1'h0);
    mem_m[a] = d;
  endtask : preload

  // one host command, every returned byte compared against the array model
  task automatic read_cmd(input logic rnd, input logic [7:0] a, input logic [7:0] len);
    int         k;
    logic [7:0] n;
    logic [7:0] base;
    base = rnd ? a : ctr_m;
    for (k = 0; k < 100 && cmd_ready !== 1'h1; k++)
      @(negedge clk);
    if (k == 100)
      give_up();
    cmd_valid  = 1'h1;
    cmd_random = rnd;
    cmd_addr   = a;
    cmd_len    = len;
    @(negedge clk);
    cmd_valid = 1'h0;
    n = 8'h00;
    for (k = 0; k < 60000 && done !== 1'h1; k++)
    begin
      @(negedge clk);
      if (rd_valid === 1'h1)
      begin
        chk(rd_data, exp_byte(base, n));
        n++;
      end
    end
    if (k == 60000)
      give_up();
    chk(n, len + 8'h01);
    chk(nack, 1'h0);
    ctr_m = base + len + 8'h01;
  endtask : read_cmd

  // one bit on the second link: data set while clock low, ack level caught while high
  task automatic bb_bit(input logic b);
    bb.sda_host_oe = ~b;
    repeat (12) @(negedge clk);
    bb.scl = 1'h1;
    repeat (6) @(negedge clk);
    bb_ack = bb.sda_dev_oe;
    repeat (6) @(negedge clk);
    bb.scl = 1'h0;
    repeat (12) @(negedge clk);
  endtask : bb_bit

  //////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, preload corners, three reads, then a foreign address byte
  initial
  begin
    num_errors     = 0;
    n_checks       = 0;
    seed           = 32'h52fa_9b58;
    arst_n         = 1'h0;
    ld_valid       = 1'h0;
    ld_addr        = 8'h00;
    ld_data        = 8'h00;
    cmd_valid      = 1'h0;
    cmd_random     = 1'h0;
    cmd_addr       = 8'h00;
    cmd_len        = 8'h00;
    bb.scl         = 1'h1;
    bb.sda_host_oe = 1'h0;
    bb_ack         = 1'h0;
    ctr_m          = ADDR_RST;
    repeat (20) @(negedge clk);
    chk(lk.scl, 1'h1);
    chk(lk.sda_dev_oe, 1'h0);
    chk(cmd_ready, 1'h1);
    chk(ld_ready, 1'h1);
    arst_n = 1'h1;
    @(negedge clk);
    seed = xs(seed);
    ra   = 8'h10 + 8'(seed[5:0]);
    // the wrap corner fe..02 and a random pair, all with random data
    for (int i = -2; i < 5; i++)
    begin
      seed = xs(seed);
      preload((i < 3) ? 8'(i) : ra + 8'(i - 3), seed[15:8]);
    end
    read_cmd(1'h1, 8'hfe, 8'h03);
    read_cmd(1'h0, 8'h00, 8'h00);
    read_cmd(1'h1, ra, 8'h01);
    // second memory: start, an address byte with a foreign id, then stop
    bb.sda_host_oe = 1'h1;
    repeat (12) @(negedge clk);
    bb.scl = 1'h0;
    repeat (12) @(negedge clk);
    for (int i = 7; i >= 0; i--)
      bb_bit(1'(8'hb1 >> i));
    bb_bit(1'h1);
    chk(bb_ack, 1'h0);
    bb.sda_host_oe = 1'h1;
    repeat (12) @(negedge clk);
    bb.scl = 1'h1;
    repeat (12) @(negedge clk);
    bb.sda_host_oe = 1'h0;
    repeat (12) @(negedge clk);
    chk(bb.sda_dev_oe, 1'h0);
    conclude();
  end
endmodule : serial_eeprom_read_sequencer_tb
`default_nettype wire
